// file: design/fctd_regs.svh
// Field positions and match patterns of the coprocessor transfer decoder
// Assumes halfwords arrive in fetch order, first halfword in bits 31:16 of the word
`ifndef FCTD_REGS_SVH
`define FCTD_REGS_SVH

`define FCTD_PREFIX_BIT 12
`define FCTD_DIR_BIT 4
`define FCTD_UOPC_HI 7
`define FCTD_UOPC_LO 5
`define FCTD_WIDTH_BIT 8
`define FCTD_LANE_HI 6
`define FCTD_LANE_LO 5
`define FCTD_KIND_HI 7
`define FCTD_KIND_LO 4
`define FCTD_EXTRA_BIT 7
`define FCTD_MBIT 5
`define FCTD_RT_HI 15
`define FCTD_RT_LO 12

`define FCTD_SP32_MASK1 16'hEF00
`define FCTD_SP32_VAL1 16'hEE00
`define FCTD_SP32_MASK2 16'h0E10
`define FCTD_SP32_VAL2 16'h0A10
`define FCTD_SP64_MASK1 16'hEFE0
`define FCTD_SP64_VAL1 16'hEC40
`define FCTD_SP64_MASK2 16'h0E00
`define FCTD_SP64_VAL2 16'h0A00

`define FCTD_UOPC_MOVE 3'h0
`define FCTD_UOPC_SPECIAL 3'h7
`define FCTD_LANE_ZERO 2'h0
`define FCTD_KIND_MASK 4'hD
`define FCTD_KIND_VAL 4'h1

`endif

// file: design/fctd_pkg.sv
// Types shared by the coprocessor transfer decoder
// Assumes the constants header is included by the modules that need numbers
`default_nettype none

package fctd_pkg;

    typedef enum logic [2:0] {
        FCTD_OP_NONE = 3'h0,
        FCTD_OP_FP_MOVE = 3'h1,
        FCTD_OP_WRITE_FP_SPECIAL = 3'h2,
        FCTD_OP_READ_FP_SPECIAL = 3'h3,
        FCTD_OP_CORE_TO_SCALAR = 3'h4,
        FCTD_OP_SCALAR_TO_CORE = 3'h5,
        FCTD_OP_PAIR_SINGLE = 3'h6,
        FCTD_OP_PAIR_DOUBLE = 3'h7
    } fctd_op_e;

    typedef struct packed {
        logic valid;
        logic [15:0] hw_first;
        logic [15:0] hw_second;
    } fctd_fetch_s;

    typedef struct packed {
        logic valid;
        logic in_space;
        logic undefined;
        logic usage_fault;
        fctd_op_e op;
        logic to_core;
        logic [3:0] rt;
        logic [3:0] rt2;
        logic [4:0] fp_idx;
        logic lane;
        logic [3:0] special_idx;
    } fctd_dec_s;

endpackage

`default_nettype wire

// file: design/fctd_decoder.sv
// Decoder for 32-bit and 64-bit core/floating-point register transfers
// Assumes fetch delivers both halfwords of an instruction in one cycle
// Behaviour
// RQ1: In the 32-bit transfer space a set prefix bit makes the instruction undefined with no transfer.
// RQ2: With the prefix clear, only the listed 32-bit combinations are accepted and all others are undefined.
// RQ3: The 32-bit space is the single-register coprocessor moves to and from coprocessors 10 and 11.
// RQ4: Width bit 0 and upper opcode 000 select a single-precision move whose way follows the direction bit.
// RQ5: Direction 0, width 0, upper opcode 111 select a write of a core register into an fp special register.
// RQ6: Direction 1, width 0, upper opcode 111 select a read of an fp special register into a core register.
// RQ7: Direction 0, width 1, upper opcode 00x, lane field 00 select a core register to scalar move.
// RQ8: Direction 1, width 1, upper opcode 00x, lane field 00 select a scalar to core register move.
// RQ9: In the 64-bit space a set prefix bit, or any unlisted combination, is undefined.
// RQ10: The 64-bit space is the register-pair coprocessor moves to and from coprocessors 10 and 11.
// RQ11: In the 64-bit space width 0 with transfer kind 00x1 moves two core and two single registers.
// RQ12: In the 64-bit space width 1 with transfer kind 00x1 moves two core registers and one doubleword.
// RQ13: The instruction is assembled as two halfwords in fetch order before fields are taken.
// RQ14: Every undefined result raises a usage fault instead of executing.
// RQ15: Each accepted transfer reports its operation, direction and register indices to execute.
`include "fctd_regs.svh"
`default_nettype none

module fctd_decoder
    import fctd_pkg::*;
(
    input wire logic mclk,
    input wire logic rst,
    input wire fctd_fetch_s fetch_in,
    output var fctd_dec_s dec_out
);

    logic [15:0] hw1;
    logic [15:0] hw2;
    logic [31:0] instr;
    logic t_bit;
    logic l_bit;
    logic c_bit;
    logic [2:0] uopc;
    logic [1:0] lane_f;
    logic [3:0] kind;
    logic [3:0] rt_f;
    logic sp32;
    logic sp64;
    logic kind_ok;
    fctd_dec_s dec_next;
    fctd_dec_s dec_reg;

    // Halfword order, not word byte order
    assign instr = {fetch_in.hw_first, fetch_in.hw_second}; // [RQ13]
    assign hw1 = instr[31:16];
    assign hw2 = instr[15:0];

    assign t_bit = hw1[`FCTD_PREFIX_BIT];
    assign l_bit = hw1[`FCTD_DIR_BIT];
    assign uopc = hw1[`FCTD_UOPC_HI:`FCTD_UOPC_LO];
    assign c_bit = hw2[`FCTD_WIDTH_BIT];
    assign lane_f = hw2[`FCTD_LANE_HI:`FCTD_LANE_LO];
    assign kind = hw2[`FCTD_KIND_HI:`FCTD_KIND_LO];
    assign rt_f = hw2[`FCTD_RT_HI:`FCTD_RT_LO];

    // Coprocessor field 101x selects numbers 10 and 11
    assign sp32 = ((hw1 & `FCTD_SP32_MASK1) == `FCTD_SP32_VAL1) && // [RQ3]
                  ((hw2 & `FCTD_SP32_MASK2) == `FCTD_SP32_VAL2);
    assign sp64 = ((hw1 & `FCTD_SP64_MASK1) == `FCTD_SP64_VAL1) && // [RQ10]
                  ((hw2 & `FCTD_SP64_MASK2) == `FCTD_SP64_VAL2);
    assign kind_ok = (kind & `FCTD_KIND_MASK) == `FCTD_KIND_VAL;

    always_comb begin
        dec_next = '0;
        dec_next.valid = fetch_in.valid;
        // Empty slots leave every field at zero
        if (fetch_in.valid) begin
            dec_next.rt = rt_f; // [RQ15]
        end
        if (fetch_in.valid && sp32) begin
            dec_next.in_space = 1'b1;
            dec_next.to_core = l_bit; // [RQ15]
            dec_next.special_idx = hw1[3:0];
            if (t_bit) begin
                dec_next.undefined = 1'b1; // [RQ1]
            end else if (!c_bit && uopc == `FCTD_UOPC_MOVE) begin
                dec_next.op = FCTD_OP_FP_MOVE; // [RQ4]
                dec_next.fp_idx = {hw1[3:0], hw2[`FCTD_EXTRA_BIT]};
            end else if (!c_bit && uopc == `FCTD_UOPC_SPECIAL && !l_bit) begin
                dec_next.op = FCTD_OP_WRITE_FP_SPECIAL; // [RQ5]
            end else if (!c_bit && uopc == `FCTD_UOPC_SPECIAL && l_bit) begin
                dec_next.op = FCTD_OP_READ_FP_SPECIAL; // [RQ6]
            end else if (c_bit && uopc[2:1] == 2'h0 && lane_f == `FCTD_LANE_ZERO) begin
                // Lane bit sits in the low upper-opcode bit
                dec_next.op = l_bit ? FCTD_OP_SCALAR_TO_CORE : FCTD_OP_CORE_TO_SCALAR; // [RQ7] [RQ8]
                dec_next.fp_idx = {hw2[`FCTD_EXTRA_BIT], hw1[3:0]};
                dec_next.lane = uopc[0];
            end else begin
                dec_next.undefined = 1'b1; // [RQ2]
            end
        end else if (fetch_in.valid && sp64) begin
            dec_next.in_space = 1'b1;
            dec_next.to_core = l_bit; // [RQ15]
            dec_next.rt2 = hw1[3:0];
            if (t_bit || !kind_ok) begin
                dec_next.undefined = 1'b1; // [RQ9]
            end else if (!c_bit) begin
                dec_next.op = FCTD_OP_PAIR_SINGLE; // [RQ11]
                dec_next.fp_idx = {hw2[3:0], hw2[`FCTD_MBIT]};
            end else begin
                dec_next.op = FCTD_OP_PAIR_DOUBLE; // [RQ12]
                dec_next.fp_idx = {hw2[`FCTD_MBIT], hw2[3:0]};
            end
        end
        // Undefined forms never execute; they fault instead
        dec_next.usage_fault = dec_next.undefined; // [RQ14]
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            dec_reg <= '0;
        end else begin
            dec_reg <= dec_next;
        end
    end

    assign dec_out = dec_reg;

    default clocking cb @(posedge mclk);
    endclocking

    default disable iff (rst);

    property p_prefix32;
        fetch_in.valid && sp32 && t_bit |=> dec_out.undefined && dec_out.op == FCTD_OP_NONE;
    endproperty
    a_prefix32: assert property (p_prefix32) else $error("prefix set not undefined"); // [RQ1]

    property p_other32;
        fetch_in.valid && sp32 && !t_bit && !c_bit && uopc == 3'h3 |=> dec_out.undefined;
    endproperty
    a_other32: assert property (p_other32) else $error("unlisted 32-bit form accepted"); // [RQ2]

    property p_coproc;
        fetch_in.valid && hw2[11:9] != 3'h5 |=> !dec_out.in_space && !dec_out.usage_fault;
    endproperty
    a_coproc: assert property (p_coproc) else $error("foreign coprocessor decoded"); // [RQ3]

    property p_single;
        fetch_in.valid && sp32 && !t_bit && !c_bit && uopc == 3'h0
            |=> dec_out.op == FCTD_OP_FP_MOVE && dec_out.to_core == $past(l_bit);
    endproperty
    a_single: assert property (p_single) else $error("single move wrong"); // [RQ4]

    property p_wspec;
        fetch_in.valid && sp32 && !t_bit && !c_bit && !l_bit && uopc == 3'h7
            |=> dec_out.op == FCTD_OP_WRITE_FP_SPECIAL && !dec_out.to_core;
    endproperty
    a_wspec: assert property (p_wspec) else $error("special write wrong"); // [RQ5]

    property p_rspec;
        fetch_in.valid && sp32 && !t_bit && !c_bit && l_bit && uopc == 3'h7
            |=> dec_out.op == FCTD_OP_READ_FP_SPECIAL && dec_out.to_core;
    endproperty
    a_rspec: assert property (p_rspec) else $error("special read wrong"); // [RQ6]

    property p_toscalar;
        fetch_in.valid && sp32 && !t_bit && c_bit && !l_bit && uopc[2:1] == 2'h0 && lane_f == 2'h0
            |=> dec_out.op == FCTD_OP_CORE_TO_SCALAR && dec_out.lane == $past(hw1[5]);
    endproperty
    a_toscalar: assert property (p_toscalar) else $error("core to scalar wrong"); // [RQ7]

    property p_fromscalar;
        fetch_in.valid && sp32 && !t_bit && c_bit && l_bit && uopc[2:1] == 2'h0 && lane_f == 2'h0
            |=> dec_out.op == FCTD_OP_SCALAR_TO_CORE && !dec_out.undefined;
    endproperty
    a_fromscalar: assert property (p_fromscalar) else $error("scalar to core wrong"); // [RQ8]

    property p_undef64;
        fetch_in.valid && sp64 && (t_bit || kind[3]) |=> dec_out.undefined && dec_out.in_space;
    endproperty
    a_undef64: assert property (p_undef64) else $error("64-bit undefined missed"); // [RQ9]

    property p_space64;
        fetch_in.valid && sp64 && !t_bit && kind == 4'h3 |=> dec_out.in_space && !dec_out.undefined;
    endproperty
    a_space64: assert property (p_space64) else $error("64-bit form rejected"); // [RQ10]

    property p_pair_single;
        fetch_in.valid && sp64 && !t_bit && kind_ok && !c_bit
            |=> dec_out.op == FCTD_OP_PAIR_SINGLE && dec_out.rt2 == $past(hw1[3:0]);
    endproperty
    a_pair_single: assert property (p_pair_single) else $error("pair single wrong"); // [RQ11]

    property p_pair_double;
        fetch_in.valid && sp64 && !t_bit && kind_ok && c_bit
            |=> dec_out.op == FCTD_OP_PAIR_DOUBLE && dec_out.fp_idx[4] == $past(hw2[5]);
    endproperty
    a_pair_double: assert property (p_pair_double) else $error("pair double wrong"); // [RQ12]

    property p_order;
        fetch_in.valid && sp32 && !t_bit && !c_bit && uopc == 3'h0
            |=> dec_out.rt == $past(rt_f) && dec_out.fp_idx[4:1] == $past(fetch_in.hw_first[3:0]);
    endproperty
    a_order: assert property (p_order) else $error("halfword order wrong"); // [RQ13]

    property p_fault;
        dec_out.usage_fault == (dec_out.undefined && dec_out.valid)
            && !(dec_out.undefined && dec_out.op != FCTD_OP_NONE);
    endproperty
    a_fault: assert property (p_fault) else $error("fault does not track undefined"); // [RQ14]

    property p_report;
        dec_out.op != FCTD_OP_NONE |-> dec_out.valid && dec_out.in_space && !dec_out.undefined;
    endproperty
    a_report: assert property (p_report) else $error("operation without accepted transfer"); // [RQ15]

    property p_idle;
        !fetch_in.valid |=> dec_out == '0;
    endproperty
    a_idle: assert property (p_idle) else $error("empty slot left output set"); // [RQ15]

    property p_valid;
        fetch_in.valid |=> dec_out.valid && dec_out.rt == $past(rt_f);
    endproperty
    a_valid: assert property (p_valid) else $error("valid or core register lost"); // [RQ15]

    property p_special_idx;
        fetch_in.valid && sp32 |=> dec_out.special_idx == $past(hw1[3:0]) && dec_out.to_core == $past(l_bit);
    endproperty
    a_special_idx: assert property (p_special_idx) else $error("special index or direction wrong"); // [RQ15]

    property p_pair_regs;
        fetch_in.valid && sp64 && !t_bit && kind_ok
            |=> dec_out.to_core == $past(l_bit) && dec_out.rt2 == $past(hw1[3:0]);
    endproperty
    a_pair_regs: assert property (p_pair_regs) else $error("pair registers wrong"); // [RQ15]

    property p_prefix64;
        fetch_in.valid && sp64 && t_bit |=> dec_out.undefined && dec_out.op == FCTD_OP_NONE;
    endproperty
    a_prefix64: assert property (p_prefix64) else $error("64-bit prefix not undefined"); // [RQ9]

    property p_kind64;
        fetch_in.valid && sp64 && !t_bit && (!kind[0] || kind[2]) |=> dec_out.undefined && dec_out.usage_fault;
    endproperty
    a_kind64: assert property (p_kind64) else $error("64-bit unlisted kind accepted"); // [RQ9]

    property p_mid32;
        fetch_in.valid && sp32 && !t_bit && !c_bit && uopc != 3'h0 && uopc != 3'h7 |=> dec_out.undefined;
    endproperty
    a_mid32: assert property (p_mid32) else $error("unlisted width 0 form accepted"); // [RQ2]

    property p_lane32;
        fetch_in.valid && sp32 && !t_bit && c_bit && (lane_f != 2'h0 || uopc[2:1] != 2'h0)
            |=> dec_out.undefined;
    endproperty
    a_lane32: assert property (p_lane32) else $error("unlisted width 1 form accepted"); // [RQ2]

    property p_foreign;
        fetch_in.valid && !sp32 && !sp64
            |=> !dec_out.in_space && dec_out.op == FCTD_OP_NONE && !dec_out.undefined;
    endproperty
    a_foreign: assert property (p_foreign) else $error("outside form decoded"); // [RQ3] [RQ10]

    property p_scalar_idx;
        fetch_in.valid && sp32 && !t_bit && c_bit && uopc[2:1] == 2'h0 && lane_f == 2'h0
            |=> dec_out.fp_idx == {$past(hw2[7]), $past(hw1[3:0])} && dec_out.to_core == $past(l_bit);
    endproperty
    a_scalar_idx: assert property (p_scalar_idx) else $error("scalar index wrong"); // [RQ7] [RQ8]

    property p_single_idx;
        fetch_in.valid && sp64 && !t_bit && kind_ok && !c_bit
            |=> dec_out.fp_idx == {$past(hw2[3:0]), $past(hw2[5])};
    endproperty
    a_single_idx: assert property (p_single_idx) else $error("pair single index wrong"); // [RQ11]

    property p_double_idx;
        fetch_in.valid && sp64 && !t_bit && kind_ok && c_bit
            |=> dec_out.fp_idx == {$past(hw2[5]), $past(hw2[3:0])} && !dec_out.undefined;
    endproperty
    a_double_idx: assert property (p_double_idx) else $error("pair double index wrong"); // [RQ12]

    property p_fault_op;
        dec_out.usage_fault |-> dec_out.in_space && dec_out.op == FCTD_OP_NONE && dec_out.fp_idx == 5'h00;
    endproperty
    a_fault_op: assert property (p_fault_op) else $error("faulting form reports a transfer"); // [RQ14]

    property p_prefix_fault;
        fetch_in.valid && (sp32 || sp64) && t_bit |=> dec_out.usage_fault;
    endproperty
    a_prefix_fault: assert property (p_prefix_fault) else $error("prefix set without fault"); // [RQ14]

    property p_swap;
        fetch_in.valid && sp32 |=> dec_out.rt == $past(fetch_in.hw_second[15:12]);
    endproperty
    a_swap: assert property (p_swap) else $error("core register from wrong halfword"); // [RQ13]

    property p_special_none;
        fetch_in.valid && sp32 && !t_bit && !c_bit && uopc == 3'h7
            |=> dec_out.fp_idx == 5'h00 && dec_out.in_space;
    endproperty
    a_special_none: assert property (p_special_none) else $error("special move carries fp index"); // [RQ6]

    c_single: cover property (dec_out.op == FCTD_OP_FP_MOVE);
    c_special: cover property (dec_out.op == FCTD_OP_READ_FP_SPECIAL);
    c_double: cover property (dec_out.op == FCTD_OP_PAIR_DOUBLE);
    c_pair_single: cover property (dec_out.op == FCTD_OP_PAIR_SINGLE);
    c_fault: cover property (dec_out.usage_fault ##1 dec_out.op == FCTD_OP_FP_MOVE);

endmodule

`default_nettype wire

// file: test/fctd_fetch_model.sv
// Fetch stage model: hands one instruction at a time to the transfer decoder
// Assumes the bench updates the request just after each falling clock edge
`default_nettype none

module fctd_fetch_model
    import fctd_pkg::*;
(
    input wire logic mclk,
    input wire fctd_fetch_s req,
    output var fctd_fetch_s fetch_in
);
    timeunit 1ns;
    timeprecision 1ns;

    logic [31:0] idle_reg;

    initial idle_reg = 32'h0000_0000;

    // Empty slots carry changing halfwords so stale data never looks settled
    always @(posedge mclk) begin
        idle_reg <= ~{fetch_in.hw_first, fetch_in.hw_second};
    end

    always_comb begin
        fetch_in = req.valid ? req : {1'b0, idle_reg};
    end
endmodule

`default_nettype wire

// file: test/fctd_decoder_tb.sv
// Self-checking bench for the coprocessor transfer decoder
// Assumes one cycle latency from fetch to decode, inputs driven on the falling edge
`default_nettype none

module fctd_decoder_tb
    import fctd_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;

    logic mclk;
    logic rst;
    fctd_fetch_s req;
    fctd_fetch_s fetch_in;
    fctd_dec_s dec_out;
    fctd_dec_s exp_q;
    logic [31:0] seed;
    logic [31:0] r;
    int n_mismatch;
    int checked;

    fctd_fetch_model partner (.mclk(mclk), .req(req), .fetch_in(fetch_in));
    fctd_decoder uut (.mclk(mclk), .rst(rst), .fetch_in(fetch_in), .dec_out(dec_out));

    function automatic logic [31:0] xorshift(logic [31:0] x);
        x = x ^ (x << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction

    function automatic fctd_dec_s exp_dec(fctd_fetch_s q);
        fctd_dec_s e;
        logic [15:0] f;
        logic [15:0] s;
        logic s32;
        logic s64;
        e = '0;
        f = q.hw_first;
        s = q.hw_second;
        s32 = (f & 16'hEF00) == 16'hEE00 && (s & 16'h0E10) == 16'h0A10;
        s64 = (f & 16'hEFE0) == 16'hEC40 && (s & 16'h0E00) == 16'h0A00;
        if (!q.valid)
            return e;
        e.valid = 1'b1;
        e.in_space = s32 | s64;
        e.to_core = e.in_space & f[4];
        e.rt = s[15:12];
        if (s32 && !f[12]) begin
            if (!s[8] && f[7:5] == 3'h0)
                e.op = FCTD_OP_FP_MOVE;
            else if (!s[8] && f[7:5] == 3'h7)
                e.op = f[4] ? FCTD_OP_READ_FP_SPECIAL : FCTD_OP_WRITE_FP_SPECIAL;
            else if (s[8] && f[7:6] == 2'h0 && s[6:5] == 2'h0)
                e.op = f[4] ? FCTD_OP_SCALAR_TO_CORE : FCTD_OP_CORE_TO_SCALAR;
        end
        if (s64 && !f[12] && (s[7:4] & 4'hD) == 4'h1)
            e.op = s[8] ? FCTD_OP_PAIR_DOUBLE : FCTD_OP_PAIR_SINGLE;
        e.undefined = e.in_space && e.op == FCTD_OP_NONE;
        e.usage_fault = e.undefined;
        case (e.op)
            FCTD_OP_FP_MOVE: e.fp_idx = {f[3:0], s[7]};
            FCTD_OP_CORE_TO_SCALAR, FCTD_OP_SCALAR_TO_CORE: e.fp_idx = {s[7], f[3:0]};
            FCTD_OP_PAIR_SINGLE: e.fp_idx = {s[3:0], s[5]};
            FCTD_OP_PAIR_DOUBLE: e.fp_idx = {s[5], s[3:0]};
            default: e.fp_idx = 5'h00;
        endcase
        e.lane = (e.op inside {FCTD_OP_CORE_TO_SCALAR, FCTD_OP_SCALAR_TO_CORE}) ? f[5] : 1'b0;
        e.rt2 = s64 ? f[3:0] : 4'h0;
        e.special_idx = s32 ? f[3:0] : 4'h0;
        return e;
    endfunction

    task automatic check(logic [31:0] seen, logic [31:0] want, string what);
        checked++;
        if (seen !== want) begin
            n_mismatch++;
            $display("BAD %0t %s seen %h want %h", $time, what, seen, want);
        end
    endtask

    task automatic compare(fctd_dec_s e);
        fctd_dec_s d;
        logic [6:0] d_class;
        logic [6:0] e_class;
        logic [18:0] d_field;
        logic [18:0] e_field;
        d = dec_out;
        d_class = {d.valid, d.in_space, d.undefined, d.usage_fault, d.op};
        e_class = {e.valid, e.in_space, e.undefined, e.usage_fault, e.op};
        d_field = {d.to_core, d.rt, d.rt2, d.fp_idx, d.lane, d.special_idx};
        e_field = {e.to_core, e.rt, e.rt2, e.fp_idx, e.lane, e.special_idx};
        if (!e.valid) begin
            check(32'(d), 32'(e), "idle output");
        end else begin
            check(32'(d_class), 32'(e_class), "class");
            check(32'(d_field), 32'(e_field), "fields");
        end
    endtask

    // One instruction per cycle; the previous one is judged as it leaves
    task automatic step(logic v, logic [31:0] w);
        @(negedge mclk);
        compare(exp_q);
        req <= {v, w};
        exp_q = exp_dec({v, w});
    endtask

    task automatic print_verdict();
        $display("checked %0d mismatches %0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    logic [31:0] corners [15] = '{32'hEE00_1A10, 32'hFE00_1A10, 32'hEE60_1A10, 32'hEEE3_2A10,
        32'hEEF1_3A10, 32'hEE25_4B10, 32'hEE35_4B90, 32'hEE05_4B30, 32'hEE10_1B10, 32'hEC42_5A1F,
        32'hEC53_6B3A, 32'hEC42_5A50, 32'hFC42_5A10, 32'hEE00_1C10, 32'hEC52_7B70};

    initial begin
        mclk = 1'b0;
        forever #10 mclk = ~mclk;
    end

    initial begin
        #(20 * 5000);
        n_mismatch++;
        print_verdict();
    end

    initial begin
        rst = 1'b1;
        req = '0;
        exp_q = '0;
        seed = 32'h0001_8200;
        n_mismatch = 0;
        checked = 0;
        repeat (16) @(negedge mclk);
        rst = 1'b0;
        foreach (corners[i])
            step(1'b1, corners[i]);
        step(1'b0, 32'hEE00_1A10);
        step(1'b1, 32'hEE00_1A10);
        $display("corner cases done");
        repeat (1000) begin
            seed = xorshift(seed);
            r = seed;
            seed = xorshift(seed);
            if (seed[1:0] == 2'h1)
                r = (r & 32'h10FF_F1EF) | 32'hEE00_0A10;
            else if (seed[1:0] == 2'h2)
                r = (r & 32'h101F_F1FF) | 32'hEC40_0A00;
            step(|seed[4:2], r);
        end
        $display("random stream done");
        @(negedge mclk);
        compare(exp_q);
        rst <= 1'b1;
        req <= '0;
        exp_q = '0;
        @(negedge mclk);
        check(32'(dec_out), 32'h0000_0000, "reset output");
        rst <= 1'b0;
        step(1'b1, 32'hEC53_6B3A);
        step(1'b1, 32'hFE00_1A10);
        step(1'b0, 32'h0000_0000);
        $display("mid-run reset done");
        print_verdict();
    end
endmodule

`default_nettype wire
